// *** core/rtc_pkg.sv ***
// Constants, field layouts and carrier types for the real-time counter core.
// Assumes a single 40 MHz bus clock that also serves as the prescaler source.
package rtc_pkg;

	// Clock figures
	localparam int CLK_PERIOD_NS = 25;

	// Register byte offsets, one aligned word each
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_EVENT_OUTPUT_CONTROL   = 8'h04;
	localparam logic [7:0] OFS_INTERRUPT_ENABLE_CLEAR = 8'h08;
	localparam logic [7:0] OFS_INTERRUPT_ENABLE_SET = 8'h0C;
	localparam logic [7:0] OFS_FLAGS    = 8'h10;
	localparam logic [7:0] OFS_STATUS   = 8'h14;
	localparam logic [7:0] OFS_COUNT    = 8'h18;
	localparam logic [7:0] OFS_PER      = 8'h1C;
	localparam logic [7:0] OFS_CMP0     = 8'h20;
	localparam logic [7:0] OFS_CMP1     = 8'h24;
	localparam logic [7:0] OFS_MASK     = 8'h28;

	// Control word bit positions
	localparam int CTRL_SWRST    = 0;
	localparam int CTRL_ENABLE   = 1;
	localparam int CTRL_MODE_LO  = 2;
	localparam int CTRL_HOURFMT  = 6;
	localparam int CTRL_CLRMATCH = 7;
	localparam int CTRL_PRESC_LO = 8;

	// Event control bit positions
	localparam int EV_TAP_LO  = 0;
	localparam int EV_MATCH0  = 8;
	localparam int EV_MATCH1  = 9;
	localparam int EV_WRAP    = 15;

	// Flag and enable bit positions
	localparam int FL_MATCH0 = 0;
	localparam int FL_MATCH1 = 1;
	localparam int FL_SYNC   = 6;
	localparam int FL_WRAP   = 7;

	// Operating modes
	localparam logic [1:0] MODE_CNT32 = 2'h0;
	localparam logic [1:0] MODE_CNT16 = 2'h1;
	localparam logic [1:0] MODE_CAL   = 2'h2;

	// Sizes and reset values
	localparam int         TAP_N      = 8;
	localparam int         TAP_FIRST  = 2;
	localparam logic [3:0] PRESC_MAX  = 4'hA;
	localparam logic [31:0] CNT_TOP32 = 32'hFFFFFFFF;
	localparam logic [15:0] PER_RESET = 16'hFFFF;
	localparam logic [4:0] HOUR_MIDNIGHT_12 = 5'h0C;
	localparam logic [4:0] HOUR_LAST_24     = 5'h17;
	localparam logic [5:0] SEC_MIN_LAST     = 6'h3B;
	localparam logic [5:0] YEAR_LAST        = 6'h3F;
	localparam logic [3:0] MONTH_LAST       = 4'hC;

	// Control fields that are held back while enabled
	typedef struct packed {
		logic [3:0] presc;
		logic       clr_match;
		logic       hour_fmt;
		logic [1:0] mode;
	} rtc_ctrl_t;

	// Packed time/date word, seconds in the low bits
	typedef struct packed {
		logic [5:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [4:0] hour;
		logic [5:0] minute;
		logic [5:0] second;
	} rtc_cal_t;

	// Event outputs, one-cycle pulses
	typedef struct packed {
		logic             wrap;
		logic             match0;
		logic             match1;
		logic [TAP_N-1:0] tap;
	} rtc_event_t;

	localparam rtc_ctrl_t CTRL_RESET = '{presc: 4'h0, clr_match: 1'b0, hour_fmt: 1'b0,
		mode: 2'h0};

endpackage : rtc_pkg

// *** core/rtc_core.sv ***
// Real-time counter core: 32-bit counter, 16-bit counter with period, or
// seconds-to-year calendar with masked alarm; flags, interrupt and events.
// Assumes an AHB-Lite master on hclk; the prescaler source is hclk itself.
//
// Functional notes
// - 32-bit mode steps per tick, wraps, flags
// - 32-bit count fully readable and writable
// - 32-bit compare flags on next tick
// - Clear-on-match zeroes count, sets compare+wrap
// - 16-bit mode wraps at period, flags wrap
// - 16-bit count readable and writable
// - Each 16-bit compare flags on next tick
// - Hour format 12/24, writable only while disabled
// - Day and month start at one
// - Every fourth year gets February 29
// - Year 63 end rolls to year 0, wraps
// - Alarm compare flags on next tick
// - Mask selection picks compared alarm fields
// - Calendar clear-on-match sets alarm and wrap
// - Wrap, compare 0 or alarm, compare 1, sync each own flag
// - Enable set/clear registers, zeros ignored
// - Request while flag and enable both set
// - All requests ORed onto one line
// - Events fire with their matching flags
// - Event emitted only while enabled
// - Counting and events need no wake-up
// - Prescaler divides by two to the field
// - Tap events on prescaler bit n+2 rising
// - Sync flag raised when a control write without software reset, or a count, period, compare or mask write completes
`timescale 1ns/1ps

module rtc_core
	import rtc_pkg::*;
#(
	parameter int PRESC_BITS = 10
)
(
	input  wire logic        hclk,      // Bus and prescaler clock
	input  wire logic        hresetn,   // Asynchronous reset, active low
	input  wire logic        hsel,      // Slave select
	input  wire logic [31:0] haddr,     // Byte address
	input  wire logic [1:0]  htrans,    // Transfer type
	input  wire logic        hwrite,    // Write when high
	input  wire logic [2:0]  hsize,     // Transfer size, ignored: every size is served as a word
	input  wire logic [31:0] hwdata,    // Write data
	input  wire logic        hready,    // Bus ready
	output logic             hreadyout, // Never stalls
	output logic             hresp,     // Always OKAY
	output logic [31:0]      hrdata,    // Read data, registered
	output logic             irq,       // Combined interrupt request
	output rtc_event_t       events     // Event pulses, registered
);

	// Elaboration check: taps and divider need the full ten bits
	if (PRESC_BITS != 10)
		$error("rtc_core: PRESC_BITS must be 10");

	// Register state
	rtc_ctrl_t   ctrl_q, ctrl_d;
	logic        enable_q, enable_d;
	logic [15:0] evctl_q, evctl_d;
	logic [7:0]  inten_q, inten_d;
	logic [7:0]  flag_q, flag_d;
	logic [31:0] cnt_q, cnt_d;
	logic [15:0] per_q, per_d;
	logic [31:0] cmp0_q, cmp0_d;
	logic [15:0] cmp1_q, cmp1_d;
	logic [2:0]  mask_q, mask_d;
	logic [PRESC_BITS-1:0] presc_q, presc_d;
	rtc_event_t  ev_q, ev_d;
	logic        wr_pend_q, wr_pend_d;
	logic [7:0]  wr_addr_q, wr_addr_d;
	logic [31:0] hrdata_q, hrdata_d;

	// Working signals
	logic             tick;
	logic [PRESC_BITS-1:0] div_mask;
	logic [TAP_N-1:0] tap_rise;
	rtc_cal_t         cal;
	rtc_cal_t         alarm;
	rtc_cal_t         cal_start;
	logic [31:0]      alarm_care;
	logic             alarm_hit;
	logic             cal_top;
	logic             accept;

	// Days in a month; every year divisible by four is a leap year
	function automatic logic [4:0] month_days(input logic [3:0] m, input logic [5:0] y);
		case (m)
			4'h2:    month_days = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
			4'h4, 4'h6, 4'h9, 4'hB: month_days = 5'h1E;
			default: month_days = 5'h1F;
		endcase
	endfunction : month_days

	// One second forward; hour is {pm, 1..12} in 12-hour form
	function automatic rtc_cal_t cal_step(input rtc_cal_t c, input logic h12);
		rtc_cal_t n;
		logic     day_over;
		n = c;
		day_over = 1'b0;
		if (c.second != SEC_MIN_LAST)
			n.second = c.second + 6'h01;
		else
		begin
			n.second = 6'h00;
			if (c.minute != SEC_MIN_LAST)
				n.minute = c.minute + 6'h01;
			else
			begin
				n.minute = 6'h00;
				if (h12)
				begin
					if (c.hour[3:0] == 4'hB)
					begin
						n.hour = {~c.hour[4], 4'hC};
						day_over = c.hour[4];
					end
					else if (c.hour[3:0] == 4'hC)
						n.hour = {c.hour[4], 4'h1};
					else
						n.hour = c.hour + 5'h01;
				end
				else if (c.hour == HOUR_LAST_24)
				begin
					n.hour = 5'h00;
					day_over = 1'b1;
				end
				else
					n.hour = c.hour + 5'h01;
			end
		end
		if (day_over)
		begin
			if (c.day != month_days(c.month, c.year))
				n.day = c.day + 5'h01;
			else
			begin
				n.day = 5'h01;
				if (c.month != MONTH_LAST)
					n.month = c.month + 4'h1;
				else
				begin
					n.month = 4'h1;
					n.year = c.year + 6'h01;
				end
			end
		end
		cal_step = n;
	endfunction : cal_step

	// Divider mask: tick when the low field bits are all ones
	always_comb
	begin
		for (int i = 0; i < PRESC_BITS; i++)
			div_mask[i] = (i < int'(ctrl_q.presc));
	end

	assign tick = enable_q && ((presc_q & div_mask) == div_mask);

	// Tap n fires as prescaler bit n+2 is about to rise
	for (genvar n = 0; n < TAP_N; n++)
	begin : g_tap
		assign tap_rise[n] = (&presc_q[n+TAP_FIRST-1:0]) & ~presc_q[n+TAP_FIRST];
	end

	// Calendar views of the count and alarm words
	assign cal       = rtc_cal_t'(cnt_q);
	assign alarm     = rtc_cal_t'(cmp0_q);
	assign cal_start = '{year: 6'h00, month: 4'h1, day: 5'h01,
		hour: ctrl_q.hour_fmt ? HOUR_MIDNIGHT_12 : 5'h00, minute: 6'h00, second: 6'h00};
	assign cal_top   = (cal.year == YEAR_LAST) && (cal.month == MONTH_LAST)
		&& (cal.day == 5'h1F) && (cal.minute == SEC_MIN_LAST) && (cal.second == SEC_MIN_LAST)
		&& (ctrl_q.hour_fmt ? (cal.hour == 5'h1B) : (cal.hour == HOUR_LAST_24));

	// Alarm field selection; zero selects nothing and never matches
	always_comb
	begin
		case (mask_q)
			3'h0:    alarm_care = 32'h00000000;
			3'h1:    alarm_care = 32'h0000003F;
			3'h2:    alarm_care = 32'h00000FFF;
			3'h3:    alarm_care = 32'h0001FFFF;
			3'h4:    alarm_care = 32'h003FFFFF;
			3'h5:    alarm_care = 32'h03FFFFFF;
			default: alarm_care = 32'hFFFFFFFF;
		endcase
	end

	assign alarm_hit = (mask_q != 3'h0) && (((cnt_q ^ cmp0_q) & alarm_care) == 32'h00000000);

	// Address phase taken only for real transfers while the bus is ready
	assign accept = hsel && hready && htrans[1];

	// Next-state of the whole block: bus writes, counting, flags, events, read data
	always_comb
	begin
		ctrl_d    = ctrl_q;
		enable_d  = enable_q;
		evctl_d   = evctl_q;
		inten_d   = inten_q;
		flag_d    = flag_q;
		cnt_d     = cnt_q;
		per_d     = per_q;
		cmp0_d    = cmp0_q;
		cmp1_d    = cmp1_q;
		mask_d    = mask_q;
		presc_d   = presc_q;
		ev_d      = '0;
		wr_pend_d = accept && hwrite;
		wr_addr_d = haddr[7:0];
		hrdata_d  = hrdata_q;

		// Prescaler and counter run on hclk alone, with no wake-up needed
		if (enable_q)
			presc_d = presc_q + 10'h001;

		if (tick)
		begin
			case (ctrl_q.mode)
				MODE_CNT32:
				begin
					if (cnt_q == cmp0_q)
					begin
						flag_d[FL_MATCH0] = 1'b1;
						ev_d.match0 = 1'b1;
					end
					if (ctrl_q.clr_match && (cnt_q == cmp0_q))
					begin
						cnt_d = 32'h00000000;
						flag_d[FL_WRAP] = 1'b1;
						ev_d.wrap = 1'b1;
					end
					else
					begin
						cnt_d = cnt_q + 32'h00000001;
						if (cnt_q == CNT_TOP32)
						begin
							flag_d[FL_WRAP] = 1'b1;
							ev_d.wrap = 1'b1;
						end
					end
				end
				MODE_CNT16:
				begin
					if (cnt_q[15:0] == cmp0_q[15:0])
					begin
						flag_d[FL_MATCH0] = 1'b1;
						ev_d.match0 = 1'b1;
					end
					if (cnt_q[15:0] == cmp1_q)
					begin
						flag_d[FL_MATCH1] = 1'b1;
						ev_d.match1 = 1'b1;
					end
					if (cnt_q[15:0] == per_q)
					begin
						cnt_d = 32'h00000000;
						flag_d[FL_WRAP] = 1'b1;
						ev_d.wrap = 1'b1;
					end
					else
						cnt_d = {16'h0000, cnt_q[15:0] + 16'h0001};
				end
				MODE_CAL:
				begin
					if (alarm_hit)
					begin
						flag_d[FL_MATCH0] = 1'b1;
						ev_d.match0 = 1'b1;
					end
					if ((ctrl_q.clr_match && alarm_hit) || cal_top)
					begin
						cnt_d = cal_start;
						flag_d[FL_WRAP] = 1'b1;
						ev_d.wrap = 1'b1;
					end
					else
						cnt_d = cal_step(cal, ctrl_q.hour_fmt);
				end
				default:
				begin
					cnt_d = cnt_q;
				end
			endcase
		end

		// Tap events need a nonzero prescaler field
		if (enable_q && (ctrl_q.presc != 4'h0))
			ev_d.tap = tap_rise;

		// Event gates: nothing leaves while its enable bit is zero
		ev_d.tap    = ev_d.tap & evctl_q[EV_TAP_LO +: TAP_N];
		ev_d.match0 = ev_d.match0 & evctl_q[EV_MATCH0];
		ev_d.match1 = ev_d.match1 & evctl_q[EV_MATCH1];
		ev_d.wrap   = ev_d.wrap & evctl_q[EV_WRAP];

		// Data phase of a write; the counter write beats a tick in the same cycle
		if (wr_pend_q)
		begin
			case (wr_addr_q)
				OFS_CTRL:
				begin
					enable_d = hwdata[CTRL_ENABLE];
					if (!enable_q)
					begin
						ctrl_d.mode      = hwdata[CTRL_MODE_LO +: 2];
						ctrl_d.hour_fmt  = hwdata[CTRL_HOURFMT];
						ctrl_d.clr_match = hwdata[CTRL_CLRMATCH];
						ctrl_d.presc     = (hwdata[CTRL_PRESC_LO +: 4] > PRESC_MAX) ?
							PRESC_MAX : hwdata[CTRL_PRESC_LO +: 4];
					end
					flag_d[FL_SYNC] = 1'b1;
				end
				OFS_EVENT_OUTPUT_CONTROL:
				begin
					if (!enable_q)
						evctl_d = hwdata[15:0];
				end
				OFS_INTERRUPT_ENABLE_CLEAR: inten_d = inten_q & ~hwdata[7:0];
				OFS_INTERRUPT_ENABLE_SET: inten_d = inten_q | hwdata[7:0];
				OFS_FLAGS:    flag_d  = flag_q & ~hwdata[7:0];
				OFS_COUNT:
				begin
					cnt_d = (ctrl_q.mode == MODE_CNT16) ? {16'h0000, hwdata[15:0]} : hwdata;
					flag_d[FL_SYNC] = 1'b1;
				end
				OFS_PER:
				begin
					per_d = hwdata[15:0];
					flag_d[FL_SYNC] = 1'b1;
				end
				OFS_CMP0:
				begin
					cmp0_d = hwdata;
					flag_d[FL_SYNC] = 1'b1;
				end
				OFS_CMP1:
				begin
					cmp1_d = hwdata[15:0];
					flag_d[FL_SYNC] = 1'b1;
				end
				OFS_MASK:
				begin
					mask_d = hwdata[2:0];
					flag_d[FL_SYNC] = 1'b1;
				end
				default:
				begin
					mask_d = mask_q;
				end
			endcase
		end

		// Hardware sets win over a clear written in the same cycle
		if (tick)
		begin
			if ((ctrl_q.mode == MODE_CNT32) && (cnt_q == cmp0_q))
				flag_d[FL_MATCH0] = 1'b1;
			if ((ctrl_q.mode == MODE_CNT32) && ((cnt_q == CNT_TOP32)
				|| (ctrl_q.clr_match && (cnt_q == cmp0_q))))
				flag_d[FL_WRAP] = 1'b1;
			if ((ctrl_q.mode == MODE_CNT16) && (cnt_q[15:0] == cmp0_q[15:0]))
				flag_d[FL_MATCH0] = 1'b1;
			if ((ctrl_q.mode == MODE_CNT16) && (cnt_q[15:0] == cmp1_q))
				flag_d[FL_MATCH1] = 1'b1;
			if ((ctrl_q.mode == MODE_CNT16) && (cnt_q[15:0] == per_q))
				flag_d[FL_WRAP] = 1'b1;
			if ((ctrl_q.mode == MODE_CAL) && alarm_hit)
				flag_d[FL_MATCH0] = 1'b1;
			if ((ctrl_q.mode == MODE_CAL) && ((ctrl_q.clr_match && alarm_hit) || cal_top))
				flag_d[FL_WRAP] = 1'b1;
		end

		// Software reset returns every register to its reset value
		if (wr_pend_q && (wr_addr_q == OFS_CTRL) && hwdata[CTRL_SWRST])
		begin
			ctrl_d   = CTRL_RESET;
			enable_d = 1'b0;
			evctl_d  = 16'h0000;
			inten_d  = 8'h00;
			flag_d   = 8'h00;
			cnt_d    = 32'h00000000;
			per_d    = PER_RESET;
			cmp0_d   = 32'h00000000;
			cmp1_d   = 16'h0000;
			mask_d   = 3'h0;
			presc_d  = '0;
		end

		// Read data taken from next values so a read right after a write sees it
		if (accept && !hwrite)
		begin
			case (haddr[7:0])
				OFS_CTRL:     hrdata_d = {20'h00000, ctrl_d.presc, ctrl_d.clr_match,
					ctrl_d.hour_fmt, 2'h0, ctrl_d.mode, enable_d, 1'b0};
				OFS_EVENT_OUTPUT_CONTROL:   hrdata_d = {16'h0000, evctl_d};
				OFS_INTERRUPT_ENABLE_CLEAR: hrdata_d = {24'h000000, inten_d};
				OFS_INTERRUPT_ENABLE_SET: hrdata_d = {24'h000000, inten_d};
				OFS_FLAGS:    hrdata_d = {24'h000000, flag_d};
				OFS_STATUS:   hrdata_d = 32'h00000000;
				OFS_COUNT:    hrdata_d = cnt_d;
				OFS_PER:      hrdata_d = {16'h0000, per_d};
				OFS_CMP0:     hrdata_d = cmp0_d;
				OFS_CMP1:     hrdata_d = {16'h0000, cmp1_d};
				OFS_MASK:     hrdata_d = {29'h00000000, mask_d};
				default:      hrdata_d = 32'h00000000;
			endcase
		end
	end

	// State registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_q    <= CTRL_RESET;
			enable_q  <= 1'b0;
			evctl_q   <= 16'h0000;
			inten_q   <= 8'h00;
			flag_q    <= 8'h00;
			cnt_q     <= 32'h00000000;
			per_q     <= PER_RESET;
			cmp0_q    <= 32'h00000000;
			cmp1_q    <= 16'h0000;
			mask_q    <= 3'h0;
			presc_q   <= '0;
			ev_q      <= '0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_q  <= 32'h00000000;
		end
		else
		begin
			ctrl_q    <= ctrl_d;
			enable_q  <= enable_d;
			evctl_q   <= evctl_d;
			inten_q   <= inten_d;
			flag_q    <= flag_d;
			cnt_q     <= cnt_d;
			per_q     <= per_d;
			cmp0_q    <= cmp0_d;
			cmp1_q    <= cmp1_d;
			mask_q    <= mask_d;
			presc_q   <= presc_d;
			ev_q      <= ev_d;
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			hrdata_q  <= hrdata_d;
		end
	end

	// Zero-wait slave; request held until flag cleared or source disabled
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;
	assign irq       = |(flag_q & inten_q);
	assign events    = ev_q;

endmodule : rtc_core

// *** bench/rtc_evsys_model.sv ***
// Event-system side of the counter core: counts the wrap, compare, alarm and tap 0 pulses it receives.
// Assumes the core's events are one-cycle pulses on hclk.
`timescale 1ns/1ps

module rtc_evsys_model
	import rtc_pkg::*;
(
	input  wire logic        hclk,     // Bus clock
	input  wire logic        hresetn,  // Reset, active low
	input  wire rtc_event_t  events,   // Event pulses from the core
	output logic [15:0]      wrap_cnt, // Wrap pulses seen
	output logic [15:0]      m0_cnt,   // Compare 0 or alarm pulses seen
	output logic [15:0]      m1_cnt,   // Compare 1 pulses seen
	output logic [15:0]      tap_cnt   // Tap 0 pulses seen
);
	// Each pulse is one event; a level held longer would be counted once per cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wrap_cnt <= 16'h0000;
			m0_cnt   <= 16'h0000;
			m1_cnt   <= 16'h0000;
			tap_cnt  <= 16'h0000;
		end
		else
		begin
			wrap_cnt <= wrap_cnt + 16'(events.wrap);
			m0_cnt   <= m0_cnt + 16'(events.match0);
			m1_cnt   <= m1_cnt + 16'(events.match1);
			tap_cnt  <= tap_cnt + 16'(events.tap[0]);
		end
	end
endmodule : rtc_evsys_model

// *** bench/rtc_core_properties.sv ***
// Port assertions for the counter core, bound to every rtc_core.
// Assumes a single-slave AHB-Lite bus where hready follows hreadyout.
`timescale 1ns/1ps

module rtc_core_properties
	import rtc_pkg::*;
(
	input wire logic        hclk,      // Bus clock
	input wire logic        hresetn,   // Reset, active low
	input wire logic        hsel,      // Slave select
	input wire logic [31:0] haddr,     // Byte address
	input wire logic [1:0]  htrans,    // Transfer type
	input wire logic        hwrite,    // Write when high
	input wire logic [2:0]  hsize,     // Transfer size
	input wire logic [31:0] hwdata,    // Write data
	input wire logic        hready,    // Bus ready
	input wire logic        hreadyout, // Slave ready
	input wire logic        hresp,     // Response
	input wire logic [31:0] hrdata,    // Read data
	input wire logic        irq,       // Interrupt request
	input wire rtc_event_t  events     // Event pulses
);
	logic        aph_d, aph_q, en_d, en_q;
	logic [7:0]  adr_d, adr_q;
	logic [15:0] ev_d, ev_q;
	logic [3:0]  pr_d, pr_q;
	logic [10:0] evm;

	// Mirror of enable, event enables and prescaler; the last two only move while disabled or on software reset
	always_comb
	begin
		aph_d = hsel & hready & htrans[1] & hwrite;
		adr_d = haddr[7:0];
		en_d  = en_q;
		ev_d  = ev_q;
		pr_d  = pr_q;
		if (aph_q && adr_q == OFS_CTRL && hwdata[CTRL_SWRST])
		begin
			en_d = 1'b0;
			ev_d = 16'h0000;
			pr_d = 4'h0;
		end
		else if (aph_q && adr_q == OFS_CTRL)
		begin
			en_d = hwdata[CTRL_ENABLE];
			if (!en_q)
				pr_d = hwdata[CTRL_PRESC_LO+:4];
		end
		else if (aph_q && adr_q == OFS_EVENT_OUTPUT_CONTROL && !en_q)
			ev_d = hwdata[15:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			aph_q <= 1'b0;
			adr_q <= 8'h00;
			en_q  <= 1'b0;
			ev_q  <= 16'h0000;
			pr_q  <= 4'h0;
		end
		else
		begin
			aph_q <= aph_d;
			adr_q <= adr_d;
			en_q  <= en_d;
			ev_q  <= ev_d;
			pr_q  <= pr_d;
		end
	end

	assign evm = {ev_q[EV_WRAP], ev_q[EV_MATCH0], ev_q[EV_MATCH1], ev_q[7:0]};

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_bus_okay : assert property (hreadyout && !hresp)
		else $error("bus stalled or answered with an error");
	a_rdata_holds : assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
		else $error("read data moved without a read");
	a_event_gated : assert property ((events & ~(evm | $past(evm))) == 11'h000)
		else $error("event emitted while its output is off");
	a_tap_presc : assert property (|events.tap |-> (pr_q != 4'h0 || $past(pr_q) != 4'h0))
		else $error("tap event with a zero prescaler");
	a_tap0_gap : assert property (events.tap[0] |=> !events.tap[0] [*7])
		else $error("tap 0 closer than eight cycles");
	a_tap1_gap : assert property (events.tap[1] |=> !events.tap[1] [*8])
		else $error("tap 1 too soon");
	a_tap_apart : assert property (events.tap[1] |-> !events.tap[0])
		else $error("tap 0 and tap 1 together");
	a_irq_fall : assert property ($fell(irq) |-> $past(aph_q))
		else $error("interrupt dropped without a register write");

	c_tap0 : cover property (events.tap[0]);
	c_wrap : cover property (events.wrap);
	c_match1 : cover property (events.match1);
	c_irq_drop : cover property ($fell(irq));
endmodule : rtc_core_properties

bind rtc_core rtc_core_properties u_rtc_core_properties (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .events(events)
);

// *** bench/test_rtc_counter_calendar_core.sv ***
// Self-checking bench for the counter core over AHB-Lite.
// Assumes one slave on the bus and the event model as the event consumer.
`timescale 1ns/1ps

module test_rtc_counter_calendar_core;
	import rtc_pkg::*;

	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        hready, hreadyout, hresp, irq;
	logic [31:0] hrdata;
	rtc_event_t  events;
	logic [15:0] wrap_cnt, m0_cnt, m1_cnt, tap_cnt;
	int          num_errors = 0;
	int          tests_run = 0;

	// Single slave: its ready is the bus ready
	assign hready = hreadyout;

	always #(CLK_PERIOD_NS / 2.0) hclk = ~hclk;

	rtc_core u_rtc_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .events(events));

	rtc_evsys_model u_rtc_evsys_model (.hclk(hclk), .hresetn(hresetn), .events(events),
		.wrap_cnt(wrap_cnt), .m0_cnt(m0_cnt), .m1_cnt(m1_cnt), .tap_cnt(tap_cnt));

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Bounded wait for the edge that samples hready high
	task automatic wait_ready();
		int n = 0;
		@(posedge hclk);
		while (hready !== 1'b1 && n < 32)
		begin
			@(posedge hclk);
			n++;
		end
		if (hready !== 1'b1)
		begin
			num_errors++;
			close_out();
		end
	endtask : wait_ready

	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= 1'b1;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
	endtask : bus_write

	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= 1'b0;
		wait_ready();
		htrans <= 2'h0;
		wait_ready();
		d = hrdata;
	endtask : bus_read

	// Reads the flags until every bit of m is set, with a bounded number of tries
	task automatic poll(input logic [31:0] m);
		logic [31:0] v = 32'h0;
		int          n;
		for (n = 0; n < 60 && (v & m) !== m; n++)
			bus_read(OFS_FLAGS, v);
		check("flags", m, v & m);
		if ((v & m) !== m)
			close_out();
	endtask : poll

	task automatic s_regs();
		logic [31:0] v;
		bus_read(OFS_PER, v);
		check("period reset", 32'h0000FFFF, v);
		bus_write(OFS_COUNT, 32'hA5A55A5A);
		bus_read(OFS_COUNT, v);
		check("count", 32'hA5A55A5A, v);
		bus_read(8'h2C, v);
		check("unmapped", 32'h0, v);
		bus_write(OFS_INTERRUPT_ENABLE_SET, 32'h000000C1);
		bus_write(OFS_INTERRUPT_ENABLE_CLEAR, 32'h00000081);
		bus_write(OFS_INTERRUPT_ENABLE_SET, 32'h0);
		bus_read(OFS_INTERRUPT_ENABLE_SET, v);
		check("enables", 32'h00000040, v);
		#1;
		check("irq on sync", 32'h1, {31'h0, irq});
		bus_write(OFS_FLAGS, 32'h00000040);
		#1;
		check("irq cleared", 32'h0, {31'h0, irq});
	endtask : s_regs

	task automatic s_wrap32();
		logic [31:0] v;
		logic [15:0] n;
		bus_write(OFS_EVENT_OUTPUT_CONTROL, 32'h00008000);
		bus_write(OFS_COUNT, 32'hFFFFFFF0);
		n = wrap_cnt;
		bus_write(OFS_CTRL, 32'h00000002);
		poll(32'h00000080);
		bus_write(OFS_CTRL, 32'h0);
		check("wrap events", {16'h0, n + 16'h1}, {16'h0, wrap_cnt});
		bus_read(OFS_COUNT, v);
		check("count after wrap", 32'h1, {31'h0, v < 32'h40});
	endtask : s_wrap32

	task automatic s_match32();
		logic [31:0] v;
		logic [15:0] n;
		bus_write(OFS_CTRL, 32'h00000080);
		bus_write(OFS_EVENT_OUTPUT_CONTROL, 32'h00000100);
		bus_write(OFS_CMP0, 32'h00000009);
		bus_write(OFS_COUNT, 32'h0);
		bus_write(OFS_FLAGS, 32'h000000FF);
		n = m0_cnt;
		bus_write(OFS_CTRL, 32'h00000082);
		poll(32'h00000081);
		bus_write(OFS_CTRL, 32'h0);
		bus_read(OFS_COUNT, v);
		check("count cleared", 32'h1, {31'h0, v < 32'hA});
		check("match events", 32'h1, {31'h0, m0_cnt > n});
	endtask : s_match32

	task automatic s_count16();
		logic [31:0] v;
		logic [15:0] n;
		bus_write(OFS_CTRL, 32'h00000004);
		bus_write(OFS_PER, 32'h00000003);
		bus_write(OFS_CMP0, 32'h00000001);
		bus_write(OFS_CMP1, 32'h00000002);
		bus_write(OFS_COUNT, 32'h0);
		bus_write(OFS_EVENT_OUTPUT_CONTROL, 32'h00000300);
		bus_write(OFS_FLAGS, 32'h000000FF);
		n = m1_cnt;
		bus_write(OFS_CTRL, 32'h00000006);
		poll(32'h00000083);
		for (int i = 0; i < 3; i++)
		begin
			bus_read(OFS_COUNT, v);
			check("count in period", 32'h1, {31'h0, v < 32'h4});
		end
		bus_write(OFS_CTRL, 32'h0);
		check("compare 1 events", 32'h1, {31'h0, m1_cnt > n});
	endtask : s_count16

	// Calendar runs one tick per cycle here; only field carries are judged
	task automatic s_calendar(input logic [7:0] c, input logic [31:0] start, input logic [31:0] m);
		bus_write(OFS_CTRL, {24'h000000, c});
		bus_write(OFS_COUNT, start);
		bus_write(OFS_FLAGS, 32'h000000FF);
		bus_write(OFS_CTRL, {24'h000000, c | 8'h02});
		poll(m);
		bus_write(OFS_CTRL, 32'h0);
	endtask : s_calendar

	task automatic s_dates();
		logic [31:0] v;
		s_calendar(8'h08, {6'h3F, 4'hC, 5'h1F, 5'h17, 6'h3B, 6'h3B}, 32'h00000080);
		bus_read(OFS_COUNT, v);
		check("rolled date", {6'h00, 6'h00, 4'h1, 5'h01, 5'h00, 6'h00}, {6'h00, v[31:6]});
		// 12-hour form: 11 PM on the last day rolls to 12 AM, hour code 0x0C
		s_calendar(8'h48, {6'h3F, 4'hC, 5'h1F, 5'h1B, 6'h3B, 6'h3B}, 32'h00000080);
		bus_read(OFS_COUNT, v);
		check("12-hour roll", {12'h000, 6'h00, 4'h1, 5'h01, 5'h0C}, {12'h000, v[31:12]});
		bus_write(OFS_CMP0, {6'h00, 4'h0, 5'h1D, 5'h00, 6'h00, 6'h00});
		bus_write(OFS_MASK, 32'h00000004);
		s_calendar(8'h08, {6'h04, 4'h2, 5'h1C, 5'h17, 6'h3B, 6'h3B}, 32'h00000001);
		bus_read(OFS_COUNT, v);
		check("leap day", 32'h0000005D, {23'h0, v[25:17]});
		// Same alarm with clear-on-match: alarm and wrap together, value back to the start
		s_calendar(8'h88, {6'h04, 4'h2, 5'h1C, 5'h17, 6'h3B, 6'h3B}, 32'h00000081);
		bus_read(OFS_COUNT, v);
		check("cleared on alarm", {12'h000, 6'h00, 4'h1, 5'h01, 5'h00}, {12'h000, v[31:12]});
	endtask : s_dates

	task automatic s_taps();
		logic [31:0] v;
		logic [15:0] n;
		bus_write(OFS_CTRL, 32'h00000100);
		bus_write(OFS_EVENT_OUTPUT_CONTROL, 32'h00000001);
		n = tap_cnt;
		bus_write(OFS_CTRL, 32'h00000102);
		bus_write(OFS_CTRL, 32'h00000142);
		repeat (64) @(posedge hclk);
		v = {16'h0, tap_cnt - n};
		check("tap count", 32'h1, {31'h0, v >= 32'h7 && v <= 32'h9});
		bus_write(OFS_CTRL, 32'h0);
		bus_read(OFS_CTRL, v);
		check("control", 32'h00000100, v);
	endtask : s_taps

	// Main sequence: reset, then each scenario in turn
	initial
	begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		s_regs();
		s_wrap32();
		s_match32();
		s_count16();
		s_dates();
		s_taps();
		close_out();
	end
endmodule : test_rtc_counter_calendar_core
